// File: rps_pkg.sv
// Purpose: Shared constants and types for the supply-switch and pin-mode block
// Assumes: Registers sit at their printed byte offsets on the local register port
// Notes: Field positions and reset values are held here once
package rps_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_SUPPLY_SWITCH_CONTROL = 8'h26;
    localparam logic [7:0] ADDR_PIN_IO_CONFIGURATION = 8'h27;

    // Values after reset
    localparam logic [7:0] RESET_SUPPLY_SWITCH_CONTROL = 8'h00;
    localparam logic [7:0] RESET_PIN_IO_CONFIGURATION = 8'h00;

    // Supply switch control fields
    localparam int THRESHOLD_BIT = 0;
    localparam int SWITCH_MODE_LSB = 1;
    localparam logic [7:0] SUPPLY_SWITCH_WRITE_MASK = 8'h1f;

    // Switch mode codes
    localparam logic [1:0] SWITCH_MODE_LOWER_OF = 2'h3;

    // Disabled output frequency code
    localparam logic [2:0] FREQ_SELECT_OFF = 3'h7;

    // Detector timing
    localparam int CLOCK_HZ = 100_000_000;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SAMPLE_RATE_HZ = 16;
    localparam int SAMPLE_WINDOW_NS = 30_500;
    localparam int SAMPLE_PERIOD_CYCLES = CLOCK_HZ / SAMPLE_RATE_HZ;
    localparam int SAMPLE_WINDOW_CYCLES = (SAMPLE_WINDOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Default length of an interrupt pulse in cycles
    localparam int IRQ_PULSE_CYCLES = 16;

    // Event pin mode field
    typedef enum logic [1:0]
    {
        RPS_EVT_OFF = 2'h0,
        RPS_EVT_IRQ_OUT = 2'h1,
        RPS_EVT_CLK_OUT = 2'h2,
        RPS_EVT_INPUT = 2'h3
    } rps_event_mode_t;

    // First interrupt pin role field
    typedef enum logic [1:0]
    {
        RPS_ROLE_CLOCK = 2'h0,
        RPS_ROLE_BATTERY = 2'h1,
        RPS_ROLE_IRQ = 2'h2,
        RPS_ROLE_HIZ = 2'h3
    } rps_first_role_t;

    // Layout of the pin configuration register, bit 7 first
    typedef struct packed
    {
        logic clock_pin_disable;
        logic detector_pull_strength;
        logic event_pin_edge_sense;
        logic event_pin_input_type;
        rps_event_mode_t event_pin_mode_field;
        rps_first_role_t first_irq_pin_role;
    } rps_pin_io_t;

    // Two-signal view of a pin driven by the block
    typedef struct packed
    {
        logic level;
        logic drive_n;
    } rps_pin_drive_t;

endpackage

// File: rps_switch_sampler.sv
// Purpose: Periodic sample window for the mechanical switch detector
// Assumes: One clock; the window opens at the start of each sample period
// Notes: The pin level is taken on the last cycle of the window
module rps_switch_sampler #(
    parameter int PERIOD_CYCLES = rps_pkg::SAMPLE_PERIOD_CYCLES,
    parameter int WINDOW_CYCLES = rps_pkg::SAMPLE_WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Control and pin
    input wire logic i_enable,
    input wire logic i_pin,
    // Results
    output logic o_window,
    output logic o_sample,
    output logic o_strobe
);

    localparam int CW = $clog2(PERIOD_CYCLES + 1);

    initial
    begin
        if (WINDOW_CYCLES < 1 || WINDOW_CYCLES >= PERIOD_CYCLES)
            $error("Sample window must be shorter than the sample period");
    end

    logic [CW-1:0] count_r;
    logic last_in_window;

    assign last_in_window = (count_r == CW'(WINDOW_CYCLES - 1));

    // Period counter; held at zero while disabled so the first window opens at once
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            count_r <= '0;
        else if (!i_enable || count_r == CW'(PERIOD_CYCLES - 1))
            count_r <= '0;
        else
            count_r <= count_r + CW'(1);
    end

    // Pull-up window, sampled level and strobe all come from flops
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_window <= 1'b0;
            o_sample <= 1'b1;
            o_strobe <= 1'b0;
        end
        else
        begin
            o_window <= i_enable && (count_r < CW'(WINDOW_CYCLES - 1) || count_r == CW'(PERIOD_CYCLES - 1));
            o_strobe <= i_enable && last_in_window;
            if (i_enable && last_in_window)
                o_sample <= i_pin;
        end
    end

endmodule

// File: rps_pin_mode.sv
// Purpose: Supply-switch control, switch interrupt and pin-mode multiplexing
// Assumes: Supply state, clock waveform and frequency code come from neighbouring blocks
// Notes: Open-drain and two-way pins use level plus active-low drive enable
//
// Functional notes
// - Threshold bit picks low or high threshold
// - Mode 11 switches at lower of both
// - One switch interrupt enable per output
// - Switch flag sets on event, sticky
// - Enabled interrupt is pulse or flag level
// - Every switch-over pulses, flag cleared or not
// - Second interrupt only driven on main supply
// - Clock pin disable forces constant low
// - Edge sense selects rising or falling event
// - Event pin mode: off, irq, clock, input
// - Event pin outputs float on backup supply
// - Input type ignored outside input mode
// - Direct input qualified, ignored on backup
// - Switch detector samples 16 Hz, pulled window
// - Pull strength bit picks weak or strong
// - Qualified input may halt time counting
// - First pin role: clock, battery, irq, float
// - Irq role open-drain low, both supplies
// - Clock role drives only on main supply
// - Battery role follows supply state only
// - Battery role floats on main, low backup
module rps_pin_mode #(
    parameter int SAMPLE_PERIOD_CYCLES = rps_pkg::SAMPLE_PERIOD_CYCLES,
    parameter int PULSE_CYCLES = rps_pkg::IRQ_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // Register port
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Neighbouring control bits
    input wire logic i_switch_irq_enable_first,
    input wire logic i_switch_irq_enable_second,
    input wire logic i_irq_pulse_mode,
    input wire logic i_flag_clear,
    input wire logic i_stop_source_select,
    input wire logic [2:0] i_output_frequency_select,
    input wire logic i_clock_wave,
    // Supply state, high while running from backup
    input wire logic i_on_backup,
    // Supply switch controls
    output logic o_switch_threshold_high,
    output logic [1:0] o_switch_mode_field,
    output logic o_switch_lower_of,
    output logic o_supply_switch_flag,
    // Interrupt levels, active high
    output logic o_first_irq,
    output logic o_second_irq,
    // Clock pin
    output logic o_clock_pin,
    output logic o_clock_pin_oe_n,
    // First interrupt pin, open drain
    output logic o_first_interrupt_pin,
    output logic o_first_interrupt_pin_oe_n,
    // Event pin, two-way
    input wire logic i_event_pin,
    output logic o_event_pin,
    output logic o_event_pin_oe_n,
    output logic o_pullup_enable,
    output logic o_pullup_strong,
    // Qualified event results
    output logic o_event_trigger,
    output logic o_stop_request
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);

    initial
    begin
        if (PULSE_CYCLES < 1)
            $error("Interrupt pulse needs at least one cycle");
    end

    logic [7:0] switch_ctrl_r;
    rps_pkg::rps_pin_io_t pin_io_r;
    logic flag_r;
    logic backup_q_r;
    logic primed_r;
    logic [PW-1:0] pulse_cnt_r;
    logic in_level_q_r;
    logic switch_event;
    logic pulse_active;
    logic clock_off;
    logic input_mode;
    logic detector_mode;
    logic in_level;
    logic in_valid;
    logic det_window;
    logic det_sample;
    logic det_strobe;
    logic first_irq_nxt;
    logic second_irq_nxt;
    rps_pkg::rps_pin_drive_t first_pin_nxt;
    rps_pkg::rps_pin_drive_t event_pin_nxt;
    rps_pkg::rps_pin_drive_t clock_pin_nxt;

    // Register file; unused high control bits are not stored
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            switch_ctrl_r <= rps_pkg::RESET_SUPPLY_SWITCH_CONTROL;
            pin_io_r <= rps_pkg::RESET_PIN_IO_CONFIGURATION;
        end
        else if (i_reg_write)
        begin
            if (i_reg_addr == rps_pkg::ADDR_SUPPLY_SWITCH_CONTROL)
                switch_ctrl_r <= i_reg_wdata & rps_pkg::SUPPLY_SWITCH_WRITE_MASK;
            if (i_reg_addr == rps_pkg::ADDR_PIN_IO_CONFIGURATION)
                pin_io_r <= i_reg_wdata;
        end
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            o_reg_rdata <= 8'h00;
        else if (i_reg_read)
        begin
            unique case (i_reg_addr)
                rps_pkg::ADDR_SUPPLY_SWITCH_CONTROL: o_reg_rdata <= switch_ctrl_r;
                rps_pkg::ADDR_PIN_IO_CONFIGURATION: o_reg_rdata <= pin_io_r;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Switch threshold and mode drive the analog comparator
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_switch_threshold_high <= 1'b0;
            o_switch_mode_field <= 2'h0;
            o_switch_lower_of <= 1'b0;
        end
        else
        begin
            o_switch_threshold_high <= switch_ctrl_r[rps_pkg::THRESHOLD_BIT];
            o_switch_mode_field <= switch_ctrl_r[rps_pkg::SWITCH_MODE_LSB +: 2];
            o_switch_lower_of <= switch_ctrl_r[rps_pkg::SWITCH_MODE_LSB +: 2] == rps_pkg::SWITCH_MODE_LOWER_OF;
        end
    end

    // Supply state history; primed avoids a false event from the reset value
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            backup_q_r <= 1'b0;
            primed_r <= 1'b0;
        end
        else
        begin
            backup_q_r <= i_on_backup;
            primed_r <= 1'b1;
        end
    end

    // Either direction of switch-over counts as an event
    assign switch_event = primed_r && (i_on_backup != backup_q_r);

    // Sticky flag; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            flag_r <= 1'b0;
        else if (switch_event)
            flag_r <= 1'b1;
        else if (i_flag_clear)
            flag_r <= 1'b0;
    end

    // Pulse restarts on every event, independent of the flag
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            pulse_cnt_r <= '0;
        else if (switch_event)
            pulse_cnt_r <= PW'(PULSE_CYCLES);
        else if (pulse_cnt_r != '0)
            pulse_cnt_r <= pulse_cnt_r - PW'(1);
    end

    assign pulse_active = pulse_cnt_r != '0;

    // Each output has its own enable; pulse or follow the flag
    assign first_irq_nxt = i_switch_irq_enable_first && (i_irq_pulse_mode ? pulse_active : flag_r);
    assign second_irq_nxt = i_switch_irq_enable_second && (i_irq_pulse_mode ? pulse_active : flag_r);

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_supply_switch_flag <= 1'b0;
            o_first_irq <= 1'b0;
            o_second_irq <= 1'b0;
        end
        else
        begin
            o_supply_switch_flag <= flag_r;
            o_first_irq <= first_irq_nxt;
            o_second_irq <= second_irq_nxt;
        end
    end

    assign clock_off = i_output_frequency_select == rps_pkg::FREQ_SELECT_OFF;
    assign input_mode = pin_io_r.event_pin_mode_field == rps_pkg::RPS_EVT_INPUT;
    // Input type only matters in input mode
    assign detector_mode = input_mode && pin_io_r.event_pin_input_type;

    // Mechanical switch detector keeps running on backup supply
    rps_switch_sampler #(
        .PERIOD_CYCLES(SAMPLE_PERIOD_CYCLES),
        .WINDOW_CYCLES(rps_pkg::SAMPLE_WINDOW_CYCLES)
    ) u_sampler (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_enable(detector_mode),
        .i_pin(i_event_pin),
        .o_window(det_window),
        .o_sample(det_sample),
        .o_strobe(det_strobe)
    );

    // Direct input is dropped on backup; detector level holds between samples
    assign in_level = detector_mode ? det_sample : i_event_pin;
    assign in_valid = input_mode && (detector_mode || !i_on_backup);

    // Previous qualified level for edge detection; loaded with the edge sense bit while invalid
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            in_level_q_r <= 1'b0;
        else if (!in_valid)
            in_level_q_r <= pin_io_r.event_pin_edge_sense;
        else
            in_level_q_r <= in_level;
    end

    // Edge sense low means rising, high means falling; stop follows the active level
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_event_trigger <= 1'b0;
            o_stop_request <= 1'b0;
        end
        else
        begin
            o_event_trigger <= in_valid && (in_level != in_level_q_r)
                && (in_level != pin_io_r.event_pin_edge_sense);
            o_stop_request <= i_stop_source_select && in_valid
                && (in_level != pin_io_r.event_pin_edge_sense);
        end
    end

    // Pull-up only during the detector window; strength from its bit
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_pullup_enable <= 1'b0;
            o_pullup_strong <= 1'b0;
        end
        else
        begin
            o_pullup_enable <= det_window;
            o_pullup_strong <= pin_io_r.detector_pull_strength;
        end
    end

    // Clock pin floats on backup since its supply domain is down
    always_comb
    begin
        clock_pin_nxt.drive_n = i_on_backup;
        if (pin_io_r.clock_pin_disable || clock_off)
            clock_pin_nxt.level = 1'b0;
        else
            clock_pin_nxt.level = i_clock_wave;
    end

    // Event pin: push-pull outputs only on main supply
    always_comb
    begin
        event_pin_nxt.level = 1'b1;
        event_pin_nxt.drive_n = 1'b1;
        unique case (pin_io_r.event_pin_mode_field)
            rps_pkg::RPS_EVT_IRQ_OUT:
            begin
                event_pin_nxt.level = !second_irq_nxt;
                event_pin_nxt.drive_n = i_on_backup;
            end
            rps_pkg::RPS_EVT_CLK_OUT:
            begin
                event_pin_nxt.level = clock_off ? 1'b0 : i_clock_wave;
                event_pin_nxt.drive_n = i_on_backup;
            end
            rps_pkg::RPS_EVT_OFF,
            rps_pkg::RPS_EVT_INPUT:
            begin
                event_pin_nxt.drive_n = 1'b1;
            end
        endcase
    end

    // First interrupt pin is open drain: it only ever pulls low
    always_comb
    begin
        first_pin_nxt.level = 1'b0;
        first_pin_nxt.drive_n = 1'b1;
        unique case (pin_io_r.first_irq_pin_role)
            rps_pkg::RPS_ROLE_CLOCK:
                first_pin_nxt.drive_n = i_on_backup || clock_off || i_clock_wave;
            rps_pkg::RPS_ROLE_BATTERY:
                first_pin_nxt.drive_n = !i_on_backup;
            rps_pkg::RPS_ROLE_IRQ:
                first_pin_nxt.drive_n = !first_irq_nxt;
            rps_pkg::RPS_ROLE_HIZ:
                first_pin_nxt.drive_n = 1'b1;
        endcase
    end

    // Pin flops; one cycle from configuration or supply change to the pad
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_clock_pin <= 1'b0;
            o_clock_pin_oe_n <= 1'b1;
            o_event_pin <= 1'b1;
            o_event_pin_oe_n <= 1'b1;
            o_first_interrupt_pin <= 1'b0;
            o_first_interrupt_pin_oe_n <= 1'b1;
        end
        else
        begin
            o_clock_pin <= clock_pin_nxt.level;
            o_clock_pin_oe_n <= clock_pin_nxt.drive_n;
            o_event_pin <= event_pin_nxt.level;
            o_event_pin_oe_n <= event_pin_nxt.drive_n;
            o_first_interrupt_pin <= first_pin_nxt.level;
            o_first_interrupt_pin_oe_n <= first_pin_nxt.drive_n;
        end
    end

    // Checks on the outputs against their causes
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    chk_threshold_write: assert property (
        i_reg_write && i_reg_addr == rps_pkg::ADDR_SUPPLY_SWITCH_CONTROL
        |=> ##1 o_switch_threshold_high == $past(i_reg_wdata[0], 2))
        else $error("Threshold output does not follow written bit");

    chk_lower_of_mode: assert property (
        o_switch_lower_of == (o_switch_mode_field == rps_pkg::SWITCH_MODE_LOWER_OF))
        else $error("Lower-of indication disagrees with mode field");

    chk_flag_sticky: assert property (
        o_supply_switch_flag && !$past(i_flag_clear) && !i_flag_clear |=> o_supply_switch_flag)
        else $error("Switch flag dropped without a clear");

    chk_event_pulses: assert property (
        switch_event && i_switch_irq_enable_first && i_irq_pulse_mode && flag_r
        ##1 i_switch_irq_enable_first && i_irq_pulse_mode |=> o_first_irq)
        else $error("No pulse on switch-over while flag was set");

    chk_level_follows: assert property (
        !i_irq_pulse_mode && i_switch_irq_enable_second |=> o_second_irq == $past(flag_r))
        else $error("Level interrupt does not follow the flag");

    chk_event_backup_hiz: assert property (
        i_on_backup && !input_mode |=> o_event_pin_oe_n)
        else $error("Event pin driven while on backup");

    chk_battery_role: assert property (
        pin_io_r.first_irq_pin_role == rps_pkg::RPS_ROLE_BATTERY
        |=> o_first_interrupt_pin_oe_n == !$past(i_on_backup) && !o_first_interrupt_pin)
        else $error("Battery role pin state wrong");

    chk_clock_disable: assert property (
        pin_io_r.clock_pin_disable |=> !o_clock_pin)
        else $error("Disabled clock pin not held low");

    chk_no_trigger_off: assert property (
        !input_mode |=> !o_event_trigger && !o_stop_request)
        else $error("Event seen outside input mode");

    chk_pull_window: assert property (
        o_pullup_enable |-> $past(detector_mode, 2) || $past(detector_mode))
        else $error("Pull-up active outside detector mode");

endmodule

// File: rps_host_model.sv
// Purpose: Host and switch side of the event pin and first interrupt pin
// Assumes: Host or switch drives the event pin only while the block floats it
// Notes: A floating event pin shows a changing pattern unless the detector pull-up holds it high; the first pin floats high
module rps_host_model (
    // Clock
    input wire logic i_clock,
    // Block pin controls
    input wire logic i_event_oe_n,
    input wire logic i_event_level,
    input wire logic i_pullup_enable,
    input wire logic i_first_oe_n,
    // Host or switch drive
    input wire logic i_drive_en,
    input wire logic i_drive_level,
    // Resolved wires
    output logic o_event_wire,
    output logic o_first_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_r = 1'h0;
    // Undriven pin wanders so no stale level can pass as real
    always @(posedge i_clock)
        junk_r <= ~junk_r;
    // Wire level from every party's enable
    always_comb
    begin
        if (!i_event_oe_n)
            o_event_wire = i_event_level;
        else if (i_drive_en)
            o_event_wire = i_drive_level;
        else if (i_pullup_enable)
            o_event_wire = 1'h1; // Detector pull-up on open switch
        else
            o_event_wire = junk_r;
        o_first_wire = i_first_oe_n; // Host pull-up, block only pulls low
    end
endmodule

// File: tb_rps_pin_mode.sv
// Purpose: Self-checking bench for the supply-switch and pin-mode block
// Assumes: Strobe register port, inputs driven at the falling edge
// Notes: Detector period shortened to keep the run brief
module tb_rps_pin_mode;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PERIOD = 4000;
    localparam int PULSE = 16;
    logic i_clock = 1'h0, i_nrst = 1'h0, i_reg_write = 1'h0, i_reg_read = 1'h0;
    logic [7:0] i_reg_addr = 8'h0, i_reg_wdata = 8'h0, o_reg_rdata, v;
    logic i_switch_irq_enable_first = 1'h0, i_switch_irq_enable_second = 1'h0;
    logic i_irq_pulse_mode = 1'h1, i_flag_clear = 1'h0, i_stop_source_select = 1'h1;
    logic [2:0] i_output_frequency_select = 3'h0;
    logic i_clock_wave = 1'h0, i_on_backup = 1'h0, i_event_pin, drv_en = 1'h1, drv_lvl = 1'h0;
    logic o_switch_threshold_high, o_switch_lower_of, o_supply_switch_flag, o_first_irq, o_second_irq;
    logic [1:0] o_switch_mode_field;
    logic o_clock_pin, o_clock_pin_oe_n, o_first_interrupt_pin, o_first_interrupt_pin_oe_n, first_wire;
    logic o_event_pin, o_event_pin_oe_n, o_pullup_enable, o_pullup_strong, o_event_trigger, o_stop_request;
    logic rd_d1 = 1'h0, rd_d2 = 1'h0;
    logic [7:0] exp_q[$];
    int miscompares = 0, checks_done = 0, trig_n = 0, n, w;

    rps_pin_mode #(.SAMPLE_PERIOD_CYCLES(PERIOD), .PULSE_CYCLES(PULSE)) DUT (
        .i_clock, .i_nrst, .i_reg_write, .i_reg_read, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .i_switch_irq_enable_first, .i_switch_irq_enable_second, .i_irq_pulse_mode, .i_flag_clear,
        .i_stop_source_select, .i_output_frequency_select, .i_clock_wave, .i_on_backup,
        .o_switch_threshold_high, .o_switch_mode_field, .o_switch_lower_of, .o_supply_switch_flag,
        .o_first_irq, .o_second_irq, .o_clock_pin, .o_clock_pin_oe_n, .o_first_interrupt_pin,
        .o_first_interrupt_pin_oe_n, .i_event_pin, .o_event_pin, .o_event_pin_oe_n, .o_pullup_enable,
        .o_pullup_strong, .o_event_trigger, .o_stop_request
    );
    rps_host_model host (
        .i_clock, .i_event_oe_n(o_event_pin_oe_n), .i_event_level(o_event_pin),
        .i_pullup_enable(o_pullup_enable), .i_first_oe_n(o_first_interrupt_pin_oe_n),
        .i_drive_en(drv_en), .i_drive_level(drv_lvl), .o_event_wire(i_event_pin), .o_first_wire(first_wire)
    );

    // Free-running clock
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Register access, one strobe then settle time
    task automatic access(logic wr, logic [7:0] a, logic [7:0] d);
        @(negedge i_clock);
        i_reg_write = wr;
        i_reg_read = !wr;
        i_reg_addr = a;
        i_reg_wdata = d;
        if (!wr)
            exp_q.push_back(d);
        @(negedge i_clock);
        i_reg_write = 1'h0;
        i_reg_read = 1'h0;
        repeat (2) @(negedge i_clock);
    endtask

    task automatic toggle_supply();
        @(negedge i_clock);
        i_on_backup = !i_on_backup;
        repeat (2) @(negedge i_clock);
    endtask

    task automatic clear_flag();
        @(negedge i_clock);
        i_flag_clear = 1'h1;
        @(negedge i_clock);
        i_flag_clear = 1'h0;
        repeat (2) @(negedge i_clock);
    endtask

    // Read data lands on the read edge; compare one cycle later with oldest note
    always @(posedge i_clock)
    begin
        rd_d1 <= i_reg_read;
        rd_d2 <= rd_d1;
        if (o_event_trigger === 1'h1)
            trig_n++;
    end
    always @(negedge i_clock)
        if (rd_d2 && exp_q.size() > 0)
            check("rdata", o_reg_rdata, exp_q.pop_front());

    // Watchdog well beyond the expected run
    initial
    begin
        #400us;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(53));
        repeat (16) @(negedge i_clock);
        i_nrst = 1'h1;
        // Register reset values, masking, unmapped place
        access(1'h0, 8'h26, rps_pkg::RESET_SUPPLY_SWITCH_CONTROL);
        access(1'h0, 8'h27, rps_pkg::RESET_PIN_IO_CONFIGURATION);
        v = 8'($urandom());
        access(1'h1, 8'h26, v | 8'he0);
        access(1'h0, 8'h26, v & rps_pkg::SUPPLY_SWITCH_WRITE_MASK);
        check("thresh", o_switch_threshold_high, v[0]);
        check("lower", o_switch_lower_of, v[2:1] == 2'h3);
        access(1'h1, 8'h26, 8'h07);
        check("mode", {o_switch_lower_of, o_switch_mode_field, o_switch_threshold_high}, 8'h0f);
        access(1'h1, 8'h30, 8'h55);
        access(1'h0, 8'h30, 8'h00);
        // Every role and event mode on both supplies
        for (int b = 0; b < 2; b++)
            for (int m = 0; m < 4; m++)
                for (int r = 0; r < 4; r++)
                begin
                    i_on_backup = b[0];
                    access(1'h1, 8'h27, {4'h1, m[1:0], r[1:0]});
                    check("first_oe", o_first_interrupt_pin_oe_n, r == 0 ? b : r == 1 ? !b : 1);
                    check("event_oe", o_event_pin_oe_n, !(b == 0 && (m == 1 || m == 2)));
                    if (b == 0 && m != 0 && m != 3)
                        check("event_lvl", o_event_pin, m == 1);
                end
        // Unused clock stopped by frequency code or by clock pin disable
        i_on_backup = 1'h0;
        i_output_frequency_select = rps_pkg::FREQ_SELECT_OFF;
        access(1'h1, 8'h27, 8'h00);
        check("first_off", first_wire, 1'h1);
        i_output_frequency_select = 3'h0;
        i_clock_wave = 1'h1;
        access(1'h1, 8'h27, 8'h00);
        check("clk_pin", {o_clock_pin, o_clock_pin_oe_n, o_pullup_strong}, 8'h4);
        access(1'h1, 8'h27, 8'hc2);
        check("clk_off", {o_clock_pin, o_clock_pin_oe_n, o_pullup_strong}, 8'h1);
        // Switch interrupt pulses, sticky flag, level mode
        i_switch_irq_enable_first = 1'h1;
        i_switch_irq_enable_second = 1'h1;
        clear_flag();
        toggle_supply();
        check("irq_on", {o_first_irq, o_second_irq, o_supply_switch_flag, first_wire}, 8'he);
        repeat (PULSE + 4) @(negedge i_clock);
        check("irq_end", {o_first_irq, o_supply_switch_flag}, 8'h1);
        toggle_supply();
        check("irq_again", o_first_irq, 1'h1);
        i_irq_pulse_mode = 1'h0;
        repeat (PULSE + 4) @(negedge i_clock);
        check("irq_lvl", {o_first_irq, first_wire}, 8'h2);
        clear_flag();
        check("irq_clr", {o_first_irq, o_supply_switch_flag}, 8'h0);
        i_switch_irq_enable_first = 1'h0;
        toggle_supply();
        check("irq_sel", {o_first_irq, o_second_irq}, 8'h1);
        // Direct input, both edge senses, ignored on backup; the last toggle left us on backup
        i_on_backup = 1'h0;
        access(1'h1, 8'h27, 8'h0f);
        n = trig_n;
        drv_lvl = 1'h1;
        repeat (3) @(negedge i_clock);
        check("rise", {7'(trig_n - n), o_stop_request}, 8'h3);
        i_stop_source_select = 1'h0;
        repeat (2) @(negedge i_clock);
        check("stop_sel", o_stop_request, 1'h0);
        i_stop_source_select = 1'h1;
        access(1'h1, 8'h27, 8'h2f);
        n = trig_n;
        drv_lvl = 1'h0;
        repeat (3) @(negedge i_clock);
        check("fall", {7'(trig_n - n), o_stop_request}, 8'h3);
        toggle_supply();
        n = trig_n;
        drv_lvl = 1'h1;
        repeat (3) @(negedge i_clock);
        drv_lvl = 1'h0;
        repeat (3) @(negedge i_clock);
        check("ignored", {7'(trig_n - n), o_stop_request}, 8'h0);
        // Switch detector on backup with strong pull-up
        drv_en = 1'h0;
        access(1'h1, 8'h27, 8'h7c);
        check("strong", o_pullup_strong, 1'h1);
        w = 0;
        while (o_pullup_enable !== 1'h1 && w < 2 * PERIOD)
        begin
            @(negedge i_clock);
            w++;
        end
        w = 0;
        while (o_pullup_enable === 1'h1 && w < PERIOD)
        begin
            @(negedge i_clock);
            w++;
        end
        check("window", w >= rps_pkg::SAMPLE_WINDOW_CYCLES - 1 && w <= rps_pkg::SAMPLE_WINDOW_CYCLES + 1, 1'h1);
        n = trig_n;
        drv_en = 1'h1;
        w = 0;
        while (trig_n == n && w < 2 * PERIOD)
        begin
            @(negedge i_clock);
            w++;
        end
        repeat (2) @(negedge i_clock);
        check("detect", {7'(trig_n - n), o_stop_request}, 8'h3);
        tally_and_finish();
    end
endmodule
